// [hdl/dmac_pkg.sv]
// constants and shared types for the multiply-accumulate block
// assumes a single hclk domain and a 32-bit ahb-lite master
`default_nettype none
package dmac_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] DMAC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] DMAC_SHIFT_OFS  = 8'h04;
  localparam logic [7:0] DMAC_OPA_OFS    = 8'h08;
  localparam logic [7:0] DMAC_OPB_OFS    = 8'h0C;
  localparam logic [7:0] DMAC_PUSH_OFS   = 8'h10;
  localparam logic [7:0] DMAC_RES_LO_OFS = 8'h14;
  localparam logic [7:0] DMAC_RES_HI_OFS = 8'h18;
  localparam logic [7:0] DMAC_STAT_OFS   = 8'h1C;
  localparam logic [7:0] DMAC_POP_OFS    = 8'h20;
  // ctrl field positions
  localparam int DMAC_CTRL_SIGNED  = 0;
  localparam int DMAC_CTRL_SUB1    = 1;
  localparam int DMAC_CTRL_ACC     = 2;
  localparam int DMAC_CTRL_ACCSUB  = 3;
  localparam int DMAC_CTRL_CHAIN   = 4;
  localparam int DMAC_CTRL_CASC    = 5;
  localparam int DMAC_CTRL_RND     = 6;
  localparam int DMAC_CTRL_SAT     = 7;
  localparam int DMAC_CTRL_PIPE    = 8;
  localparam int DMAC_CTRL_OREG    = 9;
  localparam int DMAC_CTRL_MODE_LO = 10;
  localparam int DMAC_CTRL_WID_LO  = 12;
  localparam int DMAC_CTRL_HALF    = 14;
  localparam int DMAC_CTRL_CLR     = 15;
  localparam int DMAC_CTRL_ENA_LO  = 16;
  localparam logic [31:0] DMAC_CTRL_RESET = 32'h000F_0001;
  // widths
  localparam int DMAC_OPW  = 18;
  localparam int DMAC_PW   = 37;
  localparam int DMAC_ZW   = 38;
  localparam int DMAC_WW   = 44;
  localparam int DMAC_RNDB = 17;
  localparam int DMAC_FIFO_DEPTH = 8;
  localparam int DMAC_FIFO_WIDTH = 44;
  typedef enum logic [1:0] {DMAC_M_SUM, DMAC_M_TWO, DMAC_M_SHIFT,
                            DMAC_M_CPLX} dmac_mode_t;
  typedef enum logic [2:0] {DMAC_SH_LSL, DMAC_SH_LSR, DMAC_SH_ASL,
                            DMAC_SH_ASR, DMAC_SH_ROT} dmac_shop_t;
  typedef enum logic [1:0] {DMAC_W18, DMAC_W9, DMAC_W12,
                            DMAC_W36} dmac_width_t;
endpackage
`default_nettype wire

// [hdl/dmac_fifo.sv]
// small synchronous fifo for results
// assumes one clock and an active-low asynchronous reset
`default_nettype none
module dmac_fifo
  import dmac_pkg::*;
#(
  parameter int WIDTH = DMAC_FIFO_WIDTH,
  parameter int DEPTH = DMAC_FIFO_DEPTH
)(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  // full and empty come straight from the count
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  // storage has no reset; the count keeps stale words invisible
  always_ff @(posedge hclk)
  begin
    if (do_wr)
      mem[wr_ptr] <= in_data;
  end

  // pointers and occupancy
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      if (do_wr && !do_rd)
        count <= count + 1'b1;
      else if (do_rd && !do_wr)
        count <= count - 1'b1;
    end
  end
endmodule
`default_nettype wire

// [hdl/dmac_top.sv]
// multiply-accumulate block: two halves, ahb-lite register access
// assumes fabric drives cascade/chain inputs on hclk; operands are written over the bus
`default_nettype none
module dmac_top
  import dmac_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [17:0] cascade_in,
  output logic      [17:0] cascade_out,
  input  wire logic [43:0] chain_in,
  output logic      [43:0] chain_out,
  output logic      [43:0] result_data,
  output logic             result_valid,
  input  wire logic        result_ready
);
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // product of two 18-bit operands, signed or unsigned
  function automatic logic [36:0] dmac_mul(input logic [17:0] a,
                                           input logic [17:0] b,
                                           input logic sgn);
    logic signed [18:0] ea;
    logic signed [18:0] eb;
    logic signed [37:0] pr;
    ea = {sgn & a[17], a};
    eb = {sgn & b[17], b};
    pr = ea * eb;
    return pr[36:0];
  endfunction

  // sign or zero extension of a 38-bit value to 44 bits
  function automatic logic [43:0] dmac_ext(input logic [37:0] v,
                                           input logic sgn);
    return {{6{sgn & v[37]}}, v};
  endfunction

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] shift_ctl;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [7:0]  addr_q;
  logic        wr_q;
  logic        push;
  logic        pop;
  logic        ap_ok;

  assign ap_ok     = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign push      = wr_q & (addr_q == DMAC_PUSH_OFS);
  assign pop       = wr_q & (addr_q == DMAC_POP_OFS);

  // address phase capture, single-cycle zero-wait answer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q <= '0;
      wr_q   <= 1'b0;
    end
    else
    begin
      addr_q <= haddr[7:0];
      wr_q   <= ap_ok & hwrite;
    end
  end

  // software registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl      <= DMAC_CTRL_RESET;
      shift_ctl <= '0;
      opa       <= '0;
      opb       <= '0;
    end
    else if (wr_q)
    begin
      case (addr_q)
        DMAC_CTRL_OFS:  ctrl      <= hwdata;
        DMAC_SHIFT_OFS: shift_ctl <= hwdata;
        DMAC_OPA_OFS:   opa       <= hwdata;
        DMAC_OPB_OFS:   opb       <= hwdata;
        default:        ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------
  logic        sgn;
  logic        sub1;
  logic        acc_en;
  logic        acc_sub;
  logic        chain_en;
  logic        casc_en;
  logic        rnd_en;
  logic        sat_en;
  logic        pipe_en;
  logic        oreg_en;
  dmac_mode_t  mode;
  dmac_width_t wid;
  logic        half_sel;
  logic        clr;
  logic [3:0]  ena;
  logic        in_en;
  logic        fifo_ready;
  logic [2:0]  tok;        // sample tokens: input, pipeline, output stage
  logic        tok_p;      // token seen after the pipeline stage
  logic        tok_o;      // token seen after the output stage

  assign sgn      = ctrl[DMAC_CTRL_SIGNED];
  assign sub1     = ctrl[DMAC_CTRL_SUB1];
  assign acc_en   = ctrl[DMAC_CTRL_ACC];
  assign acc_sub  = ctrl[DMAC_CTRL_ACCSUB];
  assign chain_en = ctrl[DMAC_CTRL_CHAIN];
  assign casc_en  = ctrl[DMAC_CTRL_CASC];
  assign rnd_en   = ctrl[DMAC_CTRL_RND];
  assign sat_en   = ctrl[DMAC_CTRL_SAT];
  assign pipe_en  = ctrl[DMAC_CTRL_PIPE];
  assign oreg_en  = ctrl[DMAC_CTRL_OREG] | acc_en;
  assign mode     = dmac_mode_t'(ctrl[DMAC_CTRL_MODE_LO +: 2]);
  assign wid      = dmac_width_t'(ctrl[DMAC_CTRL_WID_LO +: 2]);
  assign half_sel = ctrl[DMAC_CTRL_HALF];
  assign clr      = ctrl[DMAC_CTRL_CLR];
  assign ena      = ctrl[DMAC_CTRL_ENA_LO +: 4];
  // a full fifo stalls the whole datapath
  assign in_en    = push & fifo_ready;
  // a bypassed stage passes its token on in the same cycle
  assign tok_p    = pipe_en ? tok[1] : tok[0];
  assign tok_o    = oreg_en ? tok[2] : tok_p;

  // ---------------------------------------------------------------
  // input registers, shared ena/clr across halves
  // ---------------------------------------------------------------
  logic [17:0] a_reg [8];
  logic [17:0] b_reg [8];

  // lane k uses ena[k/2]; lane 0 a-input may take the cascade bus
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int k = 0; k < 8; k++)
      begin
        a_reg[k] <= '0;
        b_reg[k] <= '0;
      end
    end
    else
    begin
      for (int k = 0; k < 8; k++)
      begin
        if (clr)
        begin
          a_reg[k] <= '0;
          b_reg[k] <= '0;
        end
        else if (in_en && ena[k/2])
        begin
          if (casc_en)
            a_reg[k] <= (k == 0) ? cascade_in : a_reg[k-1];
          else
            a_reg[k] <= opa[17:0] ^ 18'(k);
          b_reg[k] <= opb[17:0];
        end
      end
    end
  end
  assign cascade_out = a_reg[7];

  // ---------------------------------------------------------------
  // two-multiplier units, four per block
  // ---------------------------------------------------------------
  logic [36:0] p_unit [4];
  logic [36:0] p_reg  [4];
  logic [36:0] p_use  [4];

  // P = A0*B0 +/- A1*B1; complex mode forces re/im signs
  always_comb
  begin
    for (int u = 0; u < 4; u++)
    begin
      logic s;
      s = sub1;
      if (mode == DMAC_M_CPLX)
        s = ~u[0];
      p_unit[u] = s ?
        dmac_mul(a_reg[2*u], b_reg[2*u], sgn) -
        dmac_mul(a_reg[2*u+1], b_reg[2*u+1], sgn) :
        dmac_mul(a_reg[2*u], b_reg[2*u], sgn) +
        dmac_mul(a_reg[2*u+1], b_reg[2*u+1], sgn);
    end
  end

  // pipeline register bank, bypassable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      for (int u = 0; u < 4; u++)
        p_reg[u] <= '0;
    else if (clr)
      for (int u = 0; u < 4; u++)
        p_reg[u] <= '0;
    else if (fifo_ready)
      for (int u = 0; u < 4; u++)
        p_reg[u] <= p_unit[u];
  end
  always_comb
  begin
    for (int u = 0; u < 4; u++)
      p_use[u] = pipe_en ? p_reg[u] : p_unit[u];
  end

  // ---------------------------------------------------------------
  // second stage: accumulator per half, then one chain, rounding and shifter
  // ---------------------------------------------------------------
  logic [43:0] w_reg  [2];
  logic [43:0] next_w [2];
  logic [43:0] w_use  [2];
  logic [43:0] chained;
  logic [43:0] rounded;
  logic [43:0] final_v;
  logic [31:0] shifted;
  logic [4:0]  sh_amt;
  dmac_shop_t  sh_op;

  assign sh_amt = shift_ctl[4:0];
  assign sh_op  = dmac_shop_t'(shift_ctl[7:5]);

  // each half is independent apart from shared control
  always_comb
  begin
    for (int h = 0; h < 2; h++)
    begin
      logic [37:0] z;
      logic [37:0] e0;
      logic [37:0] e1;
      logic [43:0] zx;
      e0 = {sgn & p_use[2*h][36], p_use[2*h]};
      e1 = {sgn & p_use[2*h+1][36], p_use[2*h+1]};
      z  = e0 + e1;
      if (mode == DMAC_M_TWO || mode == DMAC_M_CPLX)
        z = e0; // lower unit alone
      zx = dmac_ext(z, sgn);
      if (acc_en)
        next_w[h] = acc_sub ? w_reg[h] - zx : w_reg[h] + zx;
      else
        next_w[h] = zx;
    end
  end

  // output register bank; the accumulate loop always goes through it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      w_reg[0] <= '0;
      w_reg[1] <= '0;
    end
    else if (clr)
    begin
      w_reg[0] <= '0;
      w_reg[1] <= '0;
    end
    else if (fifo_ready && (tok_p || acc_en == 1'b0))
    begin
      w_reg[0] <= next_w[0];
      w_reg[1] <= next_w[1];
    end
  end
  always_comb
  begin
    for (int h = 0; h < 2; h++)
      w_use[h] = oreg_en ? w_reg[h] : next_w[h];
  end

  // chain: previous half (or external block) plus this half
  assign chained = chain_en ?
    (half_sel ? w_use[0] + w_use[1] : chain_in + w_use[0]) :
    w_use[half_sel];
  assign chain_out = chained;

  // round at bit 17 then saturate to 36 bits when asked
  always_comb
  begin
    logic [43:0] r;
    logic [43:0] hi;
    logic [43:0] lo;
    r = rnd_en ? chained + 44'h000_0002_0000 : chained;
    if (rnd_en)
      r[DMAC_RNDB:0] = '0;
    hi = sgn ? 44'h007_FFFF_FFFF : 44'h00F_FFFF_FFFF;
    lo = sgn ? 44'hFF8_0000_0000 : 44'h000_0000_0000;
    rounded = r;
    if (sat_en)
    begin
      if (sgn && $signed(r) > $signed(hi))
        rounded = hi;
      else if (sgn && $signed(r) < $signed(lo))
        rounded = lo;
      else if (!sgn && r > hi)
        rounded = hi;
    end
  end

  // dynamic shifter on the 32-bit operand, op may change every cycle
  always_comb
  begin
    logic [63:0] rr;
    rr = {opa, opa} >> sh_amt;
    unique case (sh_op)
      DMAC_SH_LSL: shifted = opa << sh_amt;
      DMAC_SH_LSR: shifted = opa >> sh_amt;
      DMAC_SH_ASL: shifted = opa <<< sh_amt;
      DMAC_SH_ASR: shifted = 32'($signed(opa) >>> sh_amt);
      DMAC_SH_ROT: shifted = rr[31:0];
      default:     shifted = opa;
    endcase
  end

  // narrow widths multiply the low bits of lane 0; 18-bit and 36-bit both pass the rounded result
  always_comb
  begin
    final_v = rounded;
    if (mode == DMAC_M_SHIFT)
      final_v = {12'h000, shifted};
    else
      unique case (wid)
        DMAC_W9:  final_v = dmac_ext(38'($signed(dmac_mul(
                    {{9{sgn & a_reg[0][8]}}, a_reg[0][8:0]},
                    {{9{sgn & b_reg[0][8]}}, b_reg[0][8:0]}, sgn))),
                    sgn);
        DMAC_W12: final_v = dmac_ext(38'($signed(dmac_mul(
                    {{6{sgn & a_reg[0][11]}}, a_reg[0][11:0]},
                    {{6{sgn & b_reg[0][11]}}, b_reg[0][11:0]}, sgn))),
                    sgn);
        DMAC_W18, DMAC_W36: final_v = rounded;
      endcase
  end

  // ---------------------------------------------------------------
  // result fifo and readback
  // ---------------------------------------------------------------
  // tokens walk with their sample so the fifo never takes a stale result
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tok <= '0;
    else if (fifo_ready)
      tok <= {tok_p, tok[0], in_en};
  end

  dmac_fifo #(.WIDTH(DMAC_FIFO_WIDTH), .DEPTH(DMAC_FIFO_DEPTH)) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (tok_o),
    .in_ready  (fifo_ready),
    .in_data   (final_v),
    .out_valid (result_valid),
    .out_ready (result_ready | pop),
    .out_data  (result_data)
  );

  // read mux, data phase after address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (ap_ok && !hwrite)
      unique case (haddr[7:0])
        DMAC_CTRL_OFS:   hrdata <= ctrl;
        DMAC_SHIFT_OFS:  hrdata <= shift_ctl;
        DMAC_OPA_OFS:    hrdata <= opa;
        DMAC_OPB_OFS:    hrdata <= opb;
        DMAC_RES_LO_OFS: hrdata <= result_data[31:0];
        DMAC_RES_HI_OFS: hrdata <= {20'h00000, result_data[43:32]};
        DMAC_STAT_OFS:   hrdata <= {30'h0, fifo_ready, result_valid};
        default:         hrdata <= '0;
      endcase
  end
endmodule
`default_nettype wire

// [verif/dmac_top_monitor.sv]
// port checker for the multiply-accumulate block
// assumes the single hclk domain; attached to dmac_top by bind
`default_nettype none
module dmac_top_monitor
  import dmac_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [17:0] cascade_in,
  input wire logic [17:0] cascade_out,
  input wire logic [43:0] chain_in,
  input wire logic [43:0] chain_out,
  input wire logic [43:0] result_data,
  input wire logic        result_valid,
  input wire logic        result_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       push_ph;
  logic       rd_ph;
  logic [3:0] idle_cnt;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // address phases as the slave takes them
  assign rd_ph = hsel && hready && htrans[1] && !hwrite;
  assign push_ph = hsel && hready && htrans[1] && hwrite &&
                   haddr == {24'h000000, DMAC_PUSH_OFS};
  // cycles since the last push, saturating so it never wraps
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      idle_cnt <= 4'h0;
    else if (push_ph)
      idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hF)
      idle_cnt <= idle_cnt + 4'h1;
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  bus_ready_a: assert property (hreadyout)
    else $error("hreadyout dropped");
  bus_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  hold_valid_a: assert property (
    result_valid && !result_ready |=> result_valid)
    else $error("result valid dropped while stalled");
  hold_data_a: assert property (
    result_valid && !result_ready |=> $stable(result_data))
    else $error("result data changed while stalled");
  push_result_a: assert property (
    push_ph && !result_valid |-> ##[1:8] result_valid)
    else $error("push produced no result");
  quiet_idle_a: assert property (
    !result_valid && idle_cnt > 4'h9 |=> !result_valid)
    else $error("result appeared without a push");
  unmapped_zero_a: assert property (
    rd_ph && haddr == 32'h0000_0040 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_ph |=> $stable(hrdata))
    else $error("hrdata changed without a read");
  reset_idle_a: assert property (
    $rose(hresetn) |-> !result_valid && hreadyout)
    else $error("outputs not idle after reset");
  cover property (push_ph);
  cover property ((result_valid && !result_ready) [*4]);
  cover property (rd_ph && haddr == 32'h0000_0040);
endmodule
bind dmac_top dmac_top_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .cascade_in(cascade_in), .cascade_out(cascade_out),
  .chain_in(chain_in), .chain_out(chain_out),
  .result_data(result_data), .result_valid(result_valid),
  .result_ready(result_ready));
`default_nettype wire

// [verif/dmac_fabric.sv]
// behavioural model of the fabric logic around the block
// assumes results are taken on hclk edges where valid meets ready
`default_nettype none
module dmac_fabric
  import dmac_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        stall,
  input  wire logic [43:0] chain_val,
  output logic      [17:0] cascade_in,
  output logic      [43:0] chain_in,
  output logic             result_ready,
  input  wire logic [43:0] result_data,
  input  wire logic        result_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [43:0] rxq[$];
  // cascade line flips each cycle: nothing upstream holds it
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cascade_in <= 18'h2AAAA;
    else
      cascade_in <= ~cascade_in;
  end
  // previous half block result, registered like real fabric
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      chain_in <= 44'h000_0000_0000;
    else
      chain_in <= chain_val;
  end
  // ready follows the stall request one edge late, slow on purpose
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      result_ready <= 1'b0;
    else
    begin
      if (result_valid && result_ready)
        rxq.push_back(result_data);
      result_ready <= !stall;
    end
  end
endmodule
`default_nettype wire

// [verif/dsp_multiply_accumulate_block_tb_top.sv]
// self-checking bench: ahb-lite register tasks and result checks
// assumes dmac_top, dmac_fabric model and the bound port checker
`default_nettype none
module dsp_multiply_accumulate_block_tb_top
  import dmac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, stall;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [17:0] cascade_in, cascade_out;
  logic [43:0] chain_in, chain_out, result_data, chain_val, z;
  logic        result_valid, result_ready;
  int          n_mismatch, n_checks;
  logic [31:0] t_ctrl[8] = '{32'h000F0001, 32'h000F0001, 32'h000F0003,
    32'h000F0000, 32'h000F0001, 32'h000F0081, 32'h000F4001, 32'h000F0041};
  logic [17:0] t_a[8] = '{18'h00005, 18'h3FFF0, 18'h00100, 18'h20000,
    18'h20000, 18'h20000, 18'h3FFF0, 18'h0FFFF};
  logic [17:0] t_b[8] = '{18'h00003, 18'h00007, 18'h3FFFE, 18'h30000,
    18'h20000, 18'h20000, 18'h00007, 18'h00003};
  logic [7:0]  s_op[5] = '{8'h04, 8'h21, 8'h42, 8'h61, 8'h80};
  logic [17:0] s_a[5] = '{18'h3, 18'h6, 18'h1, 18'h40, 18'h5};
  logic [43:0] s_e[5] = '{44'h30, 44'h3, 44'h4, 44'h20, 44'h5};
  // single slave: its hreadyout is the bus hready
  assign hready = hreadyout;
  dmac_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cascade_in(cascade_in),
    .cascade_out(cascade_out), .chain_in(chain_in),
    .chain_out(chain_out), .result_data(result_data),
    .result_valid(result_valid), .result_ready(result_ready));
  dmac_fabric u_fab (.hclk(hclk), .hresetn(hresetn), .stall(stall),
    .chain_val(chain_val), .cascade_in(cascade_in),
    .chain_in(chain_in), .result_ready(result_ready),
    .result_data(result_data), .result_valid(result_valid));
  // 125 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic timeout(input string name);
    n_mismatch++;
    $display("[ERR] %s expected an answer seen none", name);
    print_verdict();
  endtask
  task automatic check(input string name, input logic [43:0] exp,
                       input logic [43:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one edge at a time until hready is sampled high
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
      timeout("hready");
  endtask
  task automatic bus_xfer(input logic [31:0] a, input logic w,
                          input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer({24'h0, a}, 1'b1, d, q);
  endtask
  task automatic push(input logic [17:0] a, input logic [17:0] b);
    wr(DMAC_OPA_OFS, {14'h0, a});
    wr(DMAC_OPB_OFS, {14'h0, b});
    wr(DMAC_PUSH_OFS, 32'h0);
  endtask
  task automatic get_res(input string name, input logic [43:0] exp);
    int n;
    n = 0;
    while (u_fab.rxq.size() == 0 && n < 200)
    begin
      @(posedge hclk);
      n++;
    end
    if (u_fab.rxq.size() == 0)
      timeout(name);
    else
      check(name, exp, u_fab.rxq.pop_front());
  endtask
  // four lanes of the chosen half, lane l sees a xor l; odd lanes subtract when c[1] is set
  function automatic logic [43:0] exp_sum(input logic [31:0] c,
    input logic [17:0] a, input logic [17:0] b);
    longint s;
    longint x;
    longint y;
    int     l;
    s = 0;
    for (int k = 0; k < 4; k++)
    begin
      l = c[14] ? k + 4 : k;
      x = c[0] ? longint'($signed(a ^ 18'(l))) : longint'(a ^ 18'(l));
      y = c[0] ? longint'($signed(b)) : longint'(b);
      s = (c[1] && k[0]) ? s - x * y : s + x * y;
    end
    if (c[6])
      s = (s + 64'sh2_0000) & ~64'sh3_FFFF;
    if (c[7] && s > 64'sh7_FFFF_FFFF)
      s = 64'sh7_FFFF_FFFF;
    return s[43:0];
  endfunction
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    hresetn = 1'b0;
    stall = 1'b0;
    chain_val = 44'h0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus_xfer({24'h0, DMAC_CTRL_OFS}, 1'b0, 32'h0, rd);
    check("ctrl reset", 44'(DMAC_CTRL_RESET), 44'(rd));
    bus_xfer({24'h0, DMAC_STAT_OFS}, 1'b0, 32'h0, rd);
    check("stat reset", 44'h2, 44'(rd[1:0]));
    wr(8'h80, 32'hFFFF_FFFF);
    bus_xfer(32'h0000_0040, 1'b0, 32'h0, rd);
    check("unmapped read", 44'h0, 44'(rd));
    bus_xfer({24'h0, DMAC_CTRL_OFS}, 1'b0, 32'h0, rd);
    check("ctrl kept", 44'(DMAC_CTRL_RESET), 44'(rd));
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      wr(DMAC_CTRL_OFS, t_ctrl[i]);
      push(t_a[i], t_b[i]);
      get_res("sum", exp_sum(t_ctrl[i], t_a[i], t_b[i]));
    end
    // nine-bit mode multiplies only the low nine bits of lane 0
    wr(DMAC_CTRL_OFS, 32'h000F1001);
    push(18'h001F0, 18'h00007);
    get_res("w9", 44'hFFF_FFFF_FF90);
    $display("test sum done");
    // feedback register kept on so the loop is never combinational
    z = exp_sum(32'h000F0001, 18'h5, 18'h3);
    wr(DMAC_CTRL_OFS, 32'h000F8205);
    wr(DMAC_CTRL_OFS, 32'h000F0205);
    for (int j = 1; j < 4; j++)
    begin
      push(18'h5, 18'h3);
      get_res("acc", 44'(j) * z);
    end
    wr(DMAC_CTRL_OFS, 32'h000F020D);
    push(18'h5, 18'h3);
    get_res("acc sub", 44'h2 * z);
    $display("test acc done");
    chain_val <= 44'h123_0000_0001;
    wr(DMAC_CTRL_OFS, 32'h000F0011);
    push(18'h5, 18'h3);
    get_res("chain", chain_val + z);
    check("chain out", chain_val + z, chain_out);
    $display("test chain done");
    // shift op changes between back-to-back pushes
    wr(DMAC_CTRL_OFS, 32'h000F0801);
    for (int i = 0; i < 5; i++)
    begin
      wr(DMAC_SHIFT_OFS, {24'h0, s_op[i]});
      push(s_a[i], 18'h0);
    end
    for (int i = 0; i < 5; i++)
      get_res("shift", s_e[i]);
    $display("test shift done");
    // fill the fifo with the far side stalled, then drain it
    wr(DMAC_CTRL_OFS, DMAC_CTRL_RESET);
    stall <= 1'b1;
    for (int i = 0; i < 10; i++)
      push(18'(i), 18'h1);
    bus_xfer({24'h0, DMAC_STAT_OFS}, 1'b0, 32'h0, rd);
    check("stat full", 44'h1, 44'(rd[1:0]));
    bus_xfer({24'h0, DMAC_RES_LO_OFS}, 1'b0, 32'h0, rd);
    check("res lo", 44'h6, 44'(rd));
    stall <= 1'b0;
    for (int i = 0; i < 8; i++)
      get_res("fifo", exp_sum(DMAC_CTRL_RESET, 18'(i), 18'h1));
    bus_xfer({24'h0, DMAC_STAT_OFS}, 1'b0, 32'h0, rd);
    check("stat empty", 44'h2, 44'(rd[1:0]));
    check("fifo extra", 44'h0, 44'(u_fab.rxq.size()));
    $display("test fifo done");
    print_verdict();
  end
endmodule
`default_nettype wire
